// File: pin_board.sv
// board model on the shared low port pins
`timescale 1ns/10ps
module pin_board (
  input  wire [2:0] pin_out,
  input  wire [2:0] pin_oe,
  input  wire [2:0] ext_level,
  output wire [2:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // pin_board

// File: pin_mux_consts.vh
// constants for the low port pin function select block
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH

// ----------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------
`define OFS_PORT_OUTPUT_LATCH  4'h0
`define OFS_PORT_DIRECTION     4'h1
`define OFS_PATTERN_ENABLE     4'h2
`define OFS_PATTERN_OUT        4'h3
`define OFS_TIMER_CTRL         4'h4
`define OFS_CH4_IO_CTRL        4'h5
`define OFS_CH3_IO_CTRL        4'h6
`define OFS_PORT_READ          4'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAT_EN_8_BIT           0
`define PAT_EN_9_BIT           1
`define PAT_EN_10_BIT          2
`define TC_COMBINE_BIT         0
`define TC_PULSE_MODE_CH3_BIT            1
`define TC_PULSE_MODE_CH4_BIT            2
`define TC_OE_A3_BIT           3
`define TC_OE_B3_BIT           4
`define TC_OE_A4_BIT           5
`define IO_A_LSB               0
`define IO_B_LSB               4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE               8'h00

`endif

// File: pin_mux_monitor.sv
// checker for the low port pin function select block
`timescale 1ns/10ps
module pin_mux_monitor (
  input wire       clk,
  input wire       reset,
  input wire       hw_standby,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire [2:0] pin_in,
  input wire [2:0] pin_oe,
  input wire       timer4_pin_a,
  input wire       timer3_pin_b,
  input wire       timer3_pin_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_idl; !reg_read |=> reg_rdata == 8'h00; endproperty
  a_idl: assert property (p_idl) else $error("stray rdata");
  property p_unm; reg_read && reg_addr[3] |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped rdata");
  property p_stb; hw_standby ##1 !reg_write ##1 reg_read && reg_addr == 4'h0
    |=> reg_rdata == 8'h00; endproperty
  a_stb: assert property (p_stb) else $error("latch kept");
  property p_dir; reg_write && !hw_standby && reg_addr == 4'h1 &&
    reg_wdata[2:0] == 3'h7 |-> ##2 pin_oe == 3'h7; endproperty
  a_dir: assert property (p_dir) else $error("no drive");
  property p_cau; $changed(pin_oe) |-> $past(reg_write, 2); endproperty
  a_cau: assert property (p_cau) else $error("oe moved");
  property p_c4; timer4_pin_a |-> $past(pin_in[2], 3); endproperty
  a_c4: assert property (p_c4) else $error("cap4a");
  property p_c3b; timer3_pin_b |-> $past(pin_in[1], 3); endproperty
  a_c3b: assert property (p_c3b) else $error("cap3b");
  property p_c3a; timer3_pin_a |-> $past(pin_in[0], 3); endproperty
  a_c3a: assert property (p_c3a) else $error("cap3a");
endmodule // pin_mux_monitor
bind port_b_low_pin_function_select pin_mux_monitor pin_mux_monitor_inst (
  .clk, .reset, .hw_standby, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .pin_in, .pin_oe, .timer4_pin_a, .timer3_pin_b, .timer3_pin_a);

// File: port_b_low_pin_function_select.v
// pin function select for the three lowest port pins
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`include "pin_mux_consts.vh"
// Function
// - pin 2 free: dir 0 input, dir 1 output or pattern 10 by enable
// - pin 2 feeds ch4 A capture when combine, pulse_mode_ch4 zero and io_a2 set
// - pin 2 drives ch4 A compare when enabled and compare mode active
// - pin 1 free: dir 0 input, dir 1 output or pattern 9 by enable
// - pin 1 feeds ch3 B capture when combine, pulse_mode_ch3 zero and io_b2 set
// - pin 1 drives ch3 B compare when enabled and compare mode active
// - pin 0 free: dir 0 input, dir 1 output or pattern 8 by enable
// - pin 0 feeds ch3 A capture when combine, pulse_mode_ch3 zero and io_a2 set
// - pin 0 drives ch3 A compare when enabled and compare mode active
// - port read gives latch for output pins, pin level for inputs
// - output latch clears on reset and hw standby
module port_b_low_pin_function_select (
  // clock and reset
  input  wire       clk,
  input  wire       reset,
  input  wire       hw_standby,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // timer compare levels
  input  wire       timer4_a_compare,
  input  wire       timer3_b_compare,
  input  wire       timer3_a_compare,
  // pins
  input  wire [2:0] pin_in,
  output reg  [2:0] pin_out,
  output reg  [2:0] pin_oe,
  // capture inputs to the timer
  output reg        timer4_pin_a,
  output reg        timer3_pin_b,
  output reg        timer3_pin_a
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] port_output_latch_q;
  reg [7:0] port_direction_reg_q;
  reg [2:0] pattern_enable_q;
  reg [2:0] pattern_out_q;
  reg [5:0] timer_ctrl_q;
  reg [7:0] ch4_io_ctrl_q;
  reg [7:0] ch3_io_ctrl_q;
  reg [2:0] pin_meta_q;
  reg [2:0] pin_sync_q;

  // compare mode: io bit 2 clear and bits 1:0 not both zero
  function cmp_sel;
    input [2:0] io;
    begin
      cmp_sel = ~io[2] & (io[1] | io[0]);
    end
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port_output_latch_q  <= `RST_BYTE;
      port_direction_reg_q <= `RST_BYTE;
      pattern_enable_q     <= 3'h0;
      pattern_out_q        <= 3'h0;
      timer_ctrl_q         <= 6'h00;
      ch4_io_ctrl_q        <= `RST_BYTE;
      ch3_io_ctrl_q        <= `RST_BYTE;
    end else if (hw_standby) begin
      port_output_latch_q  <= `RST_BYTE;
    end else if (reg_write) begin
      case (reg_addr)
        `OFS_PORT_OUTPUT_LATCH: port_output_latch_q <= reg_wdata;
        `OFS_PORT_DIRECTION:    port_direction_reg_q <= reg_wdata;
        `OFS_PATTERN_ENABLE:    pattern_enable_q <= reg_wdata[2:0];
        `OFS_PATTERN_OUT:       pattern_out_q <= reg_wdata[2:0];
        `OFS_TIMER_CTRL:        timer_ctrl_q <= reg_wdata[5:0];
        `OFS_CH4_IO_CTRL:       ch4_io_ctrl_q <= reg_wdata;
        `OFS_CH3_IO_CTRL:       ch3_io_ctrl_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  wire       combine = timer_ctrl_q[`TC_COMBINE_BIT];
  wire       pulse_mode_ch3    = timer_ctrl_q[`TC_PULSE_MODE_CH3_BIT];
  wire       pulse_mode_ch4    = timer_ctrl_q[`TC_PULSE_MODE_CH4_BIT];
  wire [2:0] io4a    = ch4_io_ctrl_q[`IO_A_LSB+2:`IO_A_LSB];
  wire [2:0] io3a    = ch3_io_ctrl_q[`IO_A_LSB+2:`IO_A_LSB];
  wire [2:0] io3b    = ch3_io_ctrl_q[`IO_B_LSB+2:`IO_B_LSB];
  wire [2:0] dir     = port_direction_reg_q[2:0];
  wire [2:0] latch   = port_output_latch_q[2:0];
  wire [2:0] own_d;
  wire [2:0] cmp_lvl = {timer4_a_compare, timer3_b_compare,
                        timer3_a_compare};
  reg  [2:0] out_d;
  reg  [2:0] oe_d;
  integer    i;

  assign own_d[2] = timer_ctrl_q[`TC_OE_A4_BIT] &
                    (combine | pulse_mode_ch4 | cmp_sel(io4a));
  assign own_d[1] = timer_ctrl_q[`TC_OE_B3_BIT] &
                    (combine | cmp_sel(io3b));
  assign own_d[0] = timer_ctrl_q[`TC_OE_A3_BIT] &
                    (combine | pulse_mode_ch3 | cmp_sel(io3a));

  always @* begin
    for (i = 0; i < 3; i = i + 1) begin
      if (own_d[i]) begin
        out_d[i] = cmp_lvl[i];
        oe_d[i]  = 1'b1;
      end else begin
        out_d[i] = pattern_enable_q[i] ? pattern_out_q[i] : latch[i];
        oe_d[i]  = dir[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out      <= 3'h0;
      pin_oe       <= 3'h0;
      timer4_pin_a <= 1'b0;
      timer3_pin_b <= 1'b0;
      timer3_pin_a <= 1'b0;
      reg_rdata    <= 8'h00;
    end else begin
      pin_out      <= out_d;
      pin_oe       <= oe_d;
      timer4_pin_a <= ~combine & ~pulse_mode_ch4 & io4a[2] & pin_sync_q[2];
      timer3_pin_b <= ~combine & ~pulse_mode_ch3 & io3b[2] & pin_sync_q[1];
      timer3_pin_a <= ~combine & ~pulse_mode_ch3 & io3a[2] & pin_sync_q[0];
      reg_rdata    <= 8'h00;
      if (reg_read) begin
        case (reg_addr)
          `OFS_PORT_OUTPUT_LATCH: reg_rdata <= port_output_latch_q;
          `OFS_PORT_DIRECTION:    reg_rdata <= port_direction_reg_q;
          `OFS_PATTERN_ENABLE:    reg_rdata <= {5'h00, pattern_enable_q};
          `OFS_PATTERN_OUT:       reg_rdata <= {5'h00, pattern_out_q};
          `OFS_TIMER_CTRL:        reg_rdata <= {2'h0, timer_ctrl_q};
          `OFS_CH4_IO_CTRL:       reg_rdata <= ch4_io_ctrl_q;
          `OFS_CH3_IO_CTRL:       reg_rdata <= ch3_io_ctrl_q;
          `OFS_PORT_READ:         reg_rdata <= {5'h00,
            (dir & latch) | (~dir & pin_sync_q)};
          default:                reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // port_b_low_pin_function_select

// File: port_b_low_pin_function_select_tb.sv
// bench for the low port pin function select block
`timescale 1ns/10ps
module port_b_low_pin_function_select_tb;
  reg        clk, reset, hw_standby, reg_write, reg_read;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg  [2:0] cmp, ext;
  wire [7:0] reg_rdata;
  wire [2:0] pin_in, pin_out, pin_oe;
  wire       t4a, t3b, t3a;
  integer    n_fail = 0, checks_done = 0;
  port_b_low_pin_function_select port_b_low_pin_function_select_inst (
    .clk, .reset, .hw_standby, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .timer4_a_compare(cmp[2]),
    .timer3_b_compare(cmp[1]), .timer3_a_compare(cmp[0]), .pin_in,
    .pin_out, .pin_oe, .timer4_pin_a(t4a), .timer3_pin_b(t3b),
    .timer3_pin_a(t3a));
  pin_board pin_board_inst (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
  task chk(input [11:0] got, input [11:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input w, input [3:0] a, input [7:0] d);
    @(posedge clk);
    reg_write <= w;
    reg_read <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    #1;
  endtask
  task rdc(input [3:0] a, input [7:0] e);
    acc(0, a, 8'h00);
    chk({4'h0, reg_rdata}, {4'h0, e});
  endtask
  task pv(input [11:0] e);
    repeat (4) @(posedge clk);
    #1;
    chk({1'b0, pin_oe, 1'b0, pin_out & pin_oe, 1'b0, t4a, t3b, t3a}, e);
  endtask
  task t_gpio;
    rdc(4'h0, 8'h00);
    rdc(4'h8, 8'h00);
    acc(1, 4'h1, 8'h07);
    acc(1, 4'h0, 8'h05);
    pv(12'h750);
    acc(1, 4'h2, 8'h07);
    acc(1, 4'h3, 8'h02);
    pv(12'h720);
    rdc(4'h7, 8'h05);
    acc(1, 4'h1, 8'h00);
    pv(12'h000);
    rdc(4'h7, 8'h06);
    $display("gpio test done");
  endtask
  task t_timer;
    @(posedge clk);
    ext <= 3'h7;
    acc(1, 4'h5, 8'h04);
    acc(1, 4'h6, 8'h44);
    pv(12'h007);
    acc(1, 4'h4, 8'h02);
    pv(12'h004);
    acc(1, 4'h4, 8'h39);
    pv(12'h720);
    acc(1, 4'h4, 8'h38);
    acc(1, 4'h6, 8'h21);
    pv(12'h324);
    acc(1, 4'h4, 8'h3E);
    pv(12'h720);
    $display("timer test done");
  endtask
  task t_stby;
    @(posedge clk);
    hw_standby <= 1'b1;
    acc(1, 4'h0, 8'hFF);
    @(posedge clk);
    hw_standby <= 1'b0;
    rdc(4'h0, 8'h00);
    $display("standby test done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_fail = n_fail + 1;
    close_out;
  end
  initial begin
    {reset, hw_standby, reg_write, reg_read} = 4'h8;
    {reg_addr, reg_wdata, cmp, ext} = 18'h00016;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_gpio;
    t_timer;
    t_stby;
    close_out;
  end
endmodule // port_b_low_pin_function_select_tb
